// ==== nsr_host_ctrl.sv ====
// host controller driving a nonvolatile sram through its pins and store busy line
// Function
// RL1: device powers up with power-loss save enabled
// RL2: supply loss starts capacitor powered save
// RL3: power-loss and hardware saves need prior write
// RL4: sequence save runs even without writes
// RL5: busy line pulled low requests save
// RL6: device holds busy low during save
// RL7: writes blocked after busy line falls
// RL8: restore runs automatically after power up
// RL9: sequence starts 0x4E38, 0xB1C7, 0x83E0
// RL10: fourth 0x7C1F, fifth 0x703F
// RL11: sixth 0x8FC0 starts a save
// RL12: save erases then programs nonvolatile cells
// RL13: intervening access abandons the sequence
// RL14: sequence reads strobed by chip select
// RL15: write strobe high for all six reads
// RL16: only low sixteen address bits compared
// RL17: sixth 0x4C63 starts a restore
// RL18: restore clears then copies, needs restore time
// RL19: sixth 0x8B45 disables power-loss save
// RL20: sixth 0x4B46 enables power-loss save
// RL21: setting persists only after a later save
// RL22: low supply refuses writes and saves (the model refuses writes and hardware saves, not sequence saves)
// RL23: held write strobe blocked until new edge
// RL24: read is select and output strobe low
// RL25: write is select and write strobe low
// RL26: no access during save or restore
`timescale 1ns/100ps
module nsr_host_ctrl #(
  parameter int REQ_DELAY_CYC = nsr_pkg::STORE_REQUEST_DELAY_CYC,
  parameter int SAVE_CYC      = nsr_pkg::SAVE_DURATION_CYC,
  parameter int RESTORE_CYC   = nsr_pkg::RESTORE_DURATION_CYC,
  parameter int PWRUP_CYC     = nsr_pkg::POWERUP_RESTORE_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          cmdValid,
  input  wire nsr_pkg::nsr_op_e              cmdOp,
  input  wire logic [nsr_pkg::ADDR_W-1:0]    cmdAddr,
  input  wire logic [nsr_pkg::DATA_W-1:0]    cmdWrData,
  output logic                               cmdReady,
  output logic                               rspValid,
  output logic [nsr_pkg::DATA_W-1:0]         rspData,
  output logic [nsr_pkg::ADDR_W-1:0]         sramAddr,
  output logic                               sramCeN,
  output logic                               sramWeN,
  output logic                               sramOeN,
  output logic [nsr_pkg::DATA_W-1:0]         dqOut,
  output logic                               dqOe,
  input  wire logic [nsr_pkg::DATA_W-1:0]    dqIn,
  input  wire logic                          busyIn,
  output logic                               busyOut,
  output logic                               busyOe
);
  import nsr_pkg::*;

  typedef enum logic [2:0] {
    ST_PWRUP,
    ST_IDLE,
    ST_ACCESS,
    ST_GAP,
    ST_NVWAIT,
    ST_HWREQ,
    ST_BUSYWAIT
  } nsr_state_e;

  nsr_state_e           state_ff, nxt_state;
  nsr_op_e              op_ff, nxt_op;
  logic [31:0]          cnt_ff, nxt_cnt;
  logic [2:0]           step_ff, nxt_step;
  logic                 pending_ff, nxt_pending;
  logic                 cmdReady_ff, nxt_cmdReady;
  logic                 rspValid_ff, nxt_rspValid;
  logic [DATA_W-1:0]    rspData_ff, nxt_rspData;
  logic [ADDR_W-1:0]    sramAddr_ff, nxt_sramAddr;
  logic                 sramCeN_ff, nxt_sramCeN;
  logic                 sramWeN_ff, nxt_sramWeN;
  logic                 sramOeN_ff, nxt_sramOeN;
  logic [DATA_W-1:0]    dqOut_ff, nxt_dqOut;
  logic                 dqOe_ff, nxt_dqOe;
  logic                 busyOe_ff, nxt_busyOe;
  logic                 busyOut_ff;
  logic                 busySync1_ff, busySync2_ff;
  logic [DATA_W-1:0]    dqSync1_ff, dqSync2_ff;

  // command decode and sequence address selection
  wire              busyHigh    = busySync2_ff;
  wire              accept      = cmdValid && cmdReady_ff;
  wire              isSeqOp     = (op_ff == NSR_OP_SAVE) || (op_ff == NSR_OP_RESTORE) ||
                                  (op_ff == NSR_OP_PLS_DISABLE) || (op_ff == NSR_OP_PLS_ENABLE);
  wire              isNvOp      = (op_ff == NSR_OP_SAVE) || (op_ff == NSR_OP_RESTORE);
  wire              cmdIsSeq    = (cmdOp == NSR_OP_SAVE) || (cmdOp == NSR_OP_RESTORE) ||
                                  (cmdOp == NSR_OP_PLS_DISABLE) || (cmdOp == NSR_OP_PLS_ENABLE);
  wire [2:0]        stepNext    = step_ff + 3'h1;
  wire              seqMore     = isSeqOp && (step_ff != SEQ_LAST_STEP);
  wire [15:0]       prefixAddr  = (stepNext == 3'h1) ? SEQ_ADDR_1 :           // [RL9]
                                  (stepNext == 3'h2) ? SEQ_ADDR_2 :
                                  (stepNext == 3'h3) ? SEQ_ADDR_3 :           // [RL10]
                                  SEQ_ADDR_4;
  wire [15:0]       lastAddr    = (op_ff == NSR_OP_SAVE)    ? SEQ_ADDR_SAVE :    // [RL11]
                                  (op_ff == NSR_OP_RESTORE) ? SEQ_ADDR_RESTORE : // [RL17]
                                  (op_ff == NSR_OP_PLS_DISABLE) ? SEQ_ADDR_PLS_DIS : // [RL19]
                                  SEQ_ADDR_PLS_EN;                             // [RL20]
  // top address bit held low, the decoder ignores it
  wire [ADDR_W-1:0] seqNextAddr = {1'b0, (stepNext == SEQ_LAST_STEP) ? lastAddr : prefixAddr}; // [RL16]
  wire [31:0]       nvCycles    = (op_ff == NSR_OP_SAVE) ? 32'(SAVE_CYC) : 32'(RESTORE_CYC);
  wire [31:0]       cntInc      = cnt_ff + 32'h1;

  // next-state logic
  always_comb begin
    nxt_state    = state_ff;
    nxt_op       = op_ff;
    nxt_cnt      = cntInc;
    nxt_step     = step_ff;
    nxt_pending  = pending_ff;
    nxt_rspValid = 1'b0;
    nxt_rspData  = rspData_ff;
    nxt_sramAddr = sramAddr_ff;
    nxt_sramCeN  = sramCeN_ff;
    nxt_sramWeN  = sramWeN_ff;
    nxt_sramOeN  = sramOeN_ff;
    nxt_dqOut    = dqOut_ff;
    nxt_dqOe     = dqOe_ff;
    nxt_busyOe   = busyOe_ff;
    case (state_ff)
      ST_PWRUP: begin
        // wait out the automatic power-up restore
        if (cnt_ff >= 32'(PWRUP_CYC) - 32'h1) begin // [RL8]
          nxt_state = ST_BUSYWAIT;
          nxt_cnt   = 32'h0;
        end
      end
      ST_IDLE: begin
        nxt_cnt = 32'h0;
        if (accept) begin
          nxt_op      = cmdOp;
          nxt_pending = 1'b1;
          nxt_step    = 3'h0;
          if (cmdOp == NSR_OP_HW_SAVE) begin
            nxt_state  = ST_HWREQ;
            nxt_busyOe = 1'b1; // [RL5]
          end else begin
            nxt_state    = ST_ACCESS;
            nxt_sramCeN  = 1'b0;
            nxt_sramAddr = cmdIsSeq ? {1'b0, SEQ_ADDR_0} : cmdAddr; // [RL9]
            // sequence steps are chip-select reads with write strobe high
            nxt_sramWeN  = (cmdOp != NSR_OP_WRITE); // [RL15] [RL25]
            nxt_sramOeN  = (cmdOp != NSR_OP_READ);  // [RL14] [RL24]
            nxt_dqOe     = (cmdOp == NSR_OP_WRITE);
            nxt_dqOut    = cmdWrData;
          end
        end
      end
      ST_ACCESS: begin
        if (cnt_ff >= 32'(ACCESS_CYC) - 32'h1) begin
          // end every cycle with a strobe edge so a held write is never left over
          nxt_state   = ST_GAP;
          nxt_sramCeN = 1'b1; // [RL23]
          nxt_sramWeN = 1'b1;
          nxt_sramOeN = 1'b1;
          nxt_dqOe    = 1'b0;
          if (op_ff == NSR_OP_READ) begin
            nxt_rspData = dqSync2_ff;
          end
        end
      end
      ST_GAP: begin
        nxt_cnt = 32'h0;
        // six reads back to back, nothing else on the bus in between
        if (seqMore) begin // [RL13]
          nxt_state    = ST_ACCESS;
          nxt_step     = stepNext;
          nxt_sramAddr = seqNextAddr;
          nxt_sramCeN  = 1'b0;
        end else if (isNvOp) begin
          nxt_state = ST_NVWAIT; // [RL26]
        end else begin
          // a new loss-save setting sticks only after a later save
          nxt_state    = ST_IDLE; // [RL21]
          nxt_pending  = 1'b0;
          nxt_rspValid = 1'b1;
        end
      end
      ST_NVWAIT: begin
        // pins stay idle until the save or restore time has run out
        if (cnt_ff >= nvCycles - 32'h1) begin // [RL11] [RL18]
          nxt_state = ST_BUSYWAIT;
          nxt_cnt   = 32'h0;
        end
      end
      ST_HWREQ: begin
        // hold the request over the store request delay, then let go
        if (cnt_ff >= 32'(REQ_DELAY_CYC) - 32'h1) begin // [RL5]
          nxt_state  = ST_BUSYWAIT;
          nxt_busyOe = 1'b0;
          nxt_cnt    = 32'h0;
        end
      end
      ST_BUSYWAIT: begin
        // no access while the device holds the busy line low
        if (cnt_ff >= 32'(BUSY_SETTLE_CYC) && busyHigh) begin // [RL6] [RL7]
          nxt_state    = ST_IDLE;
          nxt_pending  = 1'b0;
          nxt_rspValid = pending_ff;
          nxt_cnt      = 32'h0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_cmdReady = (nxt_state == ST_IDLE) && busyHigh && !accept; // [RL26]
  end

  // input synchronisers for the busy line and data pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busySync1_ff <= 1'b1;
      busySync2_ff <= 1'b1;
      dqSync1_ff   <= 8'h00;
      dqSync2_ff   <= 8'h00;
    end else begin
      busySync1_ff <= busyIn;
      busySync2_ff <= busySync1_ff;
      dqSync1_ff   <= dqIn;
      dqSync2_ff   <= dqSync1_ff;
    end
  end

  // state and pin registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_PWRUP;
      op_ff       <= NSR_OP_READ;
      cnt_ff      <= 32'h0;
      step_ff     <= 3'h0;
      pending_ff  <= 1'b0;
      cmdReady_ff <= 1'b0;
      rspValid_ff <= 1'b0;
      rspData_ff  <= 8'h00;
      sramAddr_ff <= 17'h00000;
      sramCeN_ff  <= 1'b1;
      sramWeN_ff  <= 1'b1;
      sramOeN_ff  <= 1'b1;
      dqOut_ff    <= 8'h00;
      dqOe_ff     <= 1'b0;
      busyOe_ff   <= 1'b0;
      busyOut_ff  <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      op_ff       <= nxt_op;
      cnt_ff      <= nxt_cnt;
      step_ff     <= nxt_step;
      pending_ff  <= nxt_pending;
      cmdReady_ff <= nxt_cmdReady;
      rspValid_ff <= nxt_rspValid;
      rspData_ff  <= nxt_rspData;
      sramAddr_ff <= nxt_sramAddr;
      sramCeN_ff  <= nxt_sramCeN;
      sramWeN_ff  <= nxt_sramWeN;
      sramOeN_ff  <= nxt_sramOeN;
      dqOut_ff    <= nxt_dqOut;
      dqOe_ff     <= nxt_dqOe;
      busyOe_ff   <= nxt_busyOe;
      busyOut_ff  <= 1'b0; // open drain, only ever pulls low
    end
  end

  // outputs straight from registers
  assign cmdReady = cmdReady_ff;
  assign rspValid = rspValid_ff;
  assign rspData  = rspData_ff;
  assign sramAddr = sramAddr_ff;
  assign sramCeN  = sramCeN_ff;
  assign sramWeN  = sramWeN_ff;
  assign sramOeN  = sramOeN_ff;
  assign dqOut    = dqOut_ff;
  assign dqOe     = dqOe_ff;
  assign busyOut  = busyOut_ff;
  assign busyOe   = busyOe_ff;

endmodule

// ==== nsr_pkg.sv ====
// constants, command codes and timing for the nonvolatile sram host controller
package nsr_pkg;

  // clock
  localparam int CLK_NS = 5;

  // sram access timing, slowest speed grade, plus input synchroniser latency
  localparam int ACCESS_NS   = 45;
  localparam int SYNC_STAGES = 2;
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;

  // nonvolatile timing, plain defaults (least times, rounded up)
  localparam int STORE_REQUEST_DELAY_NS      = 25000;
  localparam int SAVE_DURATION_NS            = 10000000;
  localparam int RESTORE_DURATION_NS         = 200000;
  localparam int POWERUP_RESTORE_DURATION_NS = 20000000;
  localparam int STORE_REQUEST_DELAY_CYC     = (STORE_REQUEST_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAVE_DURATION_CYC           = (SAVE_DURATION_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESTORE_DURATION_CYC        = (RESTORE_DURATION_NS + CLK_NS - 1) / CLK_NS;
  localparam int POWERUP_RESTORE_CYC         = (POWERUP_RESTORE_DURATION_NS + CLK_NS - 1) / CLK_NS;

  // cycles after releasing the busy line before its level is trusted
  localparam int BUSY_SETTLE_CYC = 4;

  // command sequence addresses on the low sixteen address bits
  localparam logic [15:0] SEQ_ADDR_0       = 16'h4E38;
  localparam logic [15:0] SEQ_ADDR_1       = 16'hB1C7;
  localparam logic [15:0] SEQ_ADDR_2       = 16'h83E0;
  localparam logic [15:0] SEQ_ADDR_3       = 16'h7C1F;
  localparam logic [15:0] SEQ_ADDR_4       = 16'h703F;
  localparam logic [15:0] SEQ_ADDR_SAVE    = 16'h8FC0;
  localparam logic [15:0] SEQ_ADDR_RESTORE = 16'h4C63;
  localparam logic [15:0] SEQ_ADDR_PLS_DIS = 16'h8B45;
  localparam logic [15:0] SEQ_ADDR_PLS_EN  = 16'h4B46;
  localparam logic [2:0]  SEQ_LAST_STEP    = 3'h5;

  // widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // host commands
  typedef enum logic [2:0] {
    NSR_OP_READ,
    NSR_OP_WRITE,
    NSR_OP_SAVE,
    NSR_OP_RESTORE,
    NSR_OP_PLS_DISABLE,
    NSR_OP_PLS_ENABLE,
    NSR_OP_HW_SAVE
  } nsr_op_e;

endpackage

// ==== nsr_host_ctrl_asserts.sv ====
// concurrent checks on the host controller pins
`timescale 1ns/100ps
module nsr_host_ctrl_asserts (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              cmdValid,
  input wire nsr_pkg::nsr_op_e  cmdOp,
  input wire logic [16:0]       cmdAddr,
  input wire logic [7:0]        cmdWrData,
  input wire logic              cmdReady,
  input wire logic              rspValid,
  input wire logic [7:0]        rspData,
  input wire logic [16:0]       sramAddr,
  input wire logic              sramCeN,
  input wire logic              sramWeN,
  input wire logic              sramOeN,
  input wire logic [7:0]        dqOut,
  input wire logic              dqOe,
  input wire logic [7:0]        dqIn,
  input wire logic              busyIn,
  input wire logic              busyOut,
  input wire logic              busyOe
);
  import nsr_pkg::*;
  logic seqOn_ff;
  wire  accept = cmdValid && cmdReady;
  wire  seqOp  = cmdOp inside {NSR_OP_SAVE, NSR_OP_RESTORE, NSR_OP_PLS_DISABLE, NSR_OP_PLS_ENABLE};
  // marks a command sequence in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) seqOn_ff <= 1'b0;
    else if (accept) seqOn_ff <= seqOp;
    else if (rspValid) seqOn_ff <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  seq_we_high_a: assert property (seqOn_ff |-> sramWeN && sramOeN) else $error("strobe low in sequence");
  save_prefix_a: assert property (accept && cmdOp == NSR_OP_SAVE |=> !sramCeN && sramAddr[15:0] == SEQ_ADDR_0
    ##12 sramAddr[15:0] == SEQ_ADDR_1 ##12 sramAddr[15:0] == SEQ_ADDR_2) else $error("bad sequence start");
  seq_tail_a: assert property (accept && seqOp |-> ##37 sramAddr[15:0] == SEQ_ADDR_3
    ##12 sramAddr[15:0] == SEQ_ADDR_4) else $error("bad sequence middle");
  restore_last_a: assert property (accept && cmdOp == NSR_OP_RESTORE |-> ##61 sramAddr[15:0] == SEQ_ADDR_RESTORE)
    else $error("bad restore address");
  seq_bit16_a: assert property (seqOn_ff && !sramCeN |-> !sramAddr[16]) else $error("sequence top bit set");
  write_pins_a: assert property (!sramWeN |-> !sramCeN && sramOeN && dqOe) else $error("bad write strobes");
  read_pins_a: assert property (!sramOeN |-> !sramCeN && sramWeN && !dqOe) else $error("bad read strobes");
  read_lat_a: assert property (accept && cmdOp == NSR_OP_READ |-> ##13 rspValid) else $error("read answer late");
  hw_pull_a: assert property (accept && cmdOp == NSR_OP_HW_SAVE |=> busyOe[*8]) else $error("busy not pulled");
  open_drain_a: assert property (busyOe |-> !busyOut && sramCeN && !cmdReady) else $error("busy driven high");
  busy_hold_a: assert property (!busyIn[*4] |-> !cmdReady) else $error("ready while busy low");
  rsp_pulse_a: assert property (rspValid |=> !rspValid) else $error("answer longer than a cycle");
endmodule
bind nsr_host_ctrl nsr_host_ctrl_asserts chk_u (.clk, .rst_n, .cmdValid, .cmdOp, .cmdAddr, .cmdWrData, .cmdReady,
  .rspValid, .rspData, .sramAddr, .sramCeN, .sramWeN, .sramOeN, .dqOut, .dqOe, .dqIn, .busyIn, .busyOut, .busyOe);

// ==== nsr_dev_model.sv ====
// behavioural nonvolatile sram answering the host pins
`timescale 1ns/100ps
module nsr_dev_model #(
  parameter int SAVE_CYC = 25,
  parameter int RCL_CYC  = 15,
  parameter int DLY_CYC  = 10
) (
  input  wire logic        clk,
  input  wire logic [16:0] addr,
  input  wire logic        ceN,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic [7:0]  dqIn,
  input  wire logic        busyW,
  input  wire logic        supplyLow,
  output logic [7:0]       dqOut,
  output logic             pull = 1'b0
);
  import nsr_pkg::*;
  localparam logic [15:0] PRE [0:4] = '{SEQ_ADDR_0, SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4};
  logic [7:0]  mem [0:131071];
  logic [7:0]  nv [0:131071];
  logic [7:0]  lastDq = 8'h00;
  logic [7:0]  dP;
  logic [16:0] aP;
  logic        ceP = 1'b1;
  logic        weP = 1'b1;
  logic        bP = 1'b1;
  logic        dirty = 1'b0;
  logic        plsEn = 1'b1;
  logic        plsNv = 1'b1;
  logic        sP = 1'b0;
  logic        wrBlk = 1'b0;
  logic [2:0]  step = 3'h0;
  int          svCnt, rcCnt, hwCnt, saveCnt;
  wire         idle = !pull && rcCnt == 0;
  wire         drv  = !ceN && !oeN && weN && busyW && idle;
  // released data pins show the inverse of the last byte
  assign dqOut = drv ? mem[addr] : ~lastDq;
  // power-up restore of a cleared array
  initial begin
    foreach (nv[i]) nv[i] = 8'h00;
    mem = nv;
  end
  task automatic startSave();
    nv = mem;
    plsNv = plsEn;
    dirty = 1'b0;
    saveCnt++;
    pull <= 1'b1;
    svCnt <= SAVE_CYC;
  endtask
  task automatic startRestore();
    mem = nv;
    dirty = 1'b0;
    rcCnt <= RCL_CYC;
  endtask
  // access ends, sequence decode and save timers
  always @(posedge clk) begin
    ceP <= ceN;
    weP <= weN;
    aP <= addr;
    dP <= dqIn;
    bP <= busyW;
    sP <= supplyLow;
    // writes held over a save or restore need a fresh falling edge
    if (!idle) wrBlk <= 1'b1;
    else if ((ceP && !ceN) || (weP && !weN)) wrBlk <= 1'b0;
    // supply loss saves from the backup capacitor, supply return restores
    if (!sP && supplyLow && plsEn && dirty && idle) startSave();
    if (sP && !supplyLow) begin
      startRestore();
      plsEn <= plsNv;
    end
    if (drv) lastDq <= mem[addr];
    if (svCnt == 1) pull <= 1'b0;
    if (svCnt > 0) svCnt <= svCnt - 1;
    if (rcCnt > 0) rcCnt <= rcCnt - 1;
    if (hwCnt == 1) startSave();
    if (hwCnt > 0) hwCnt <= hwCnt - 1;
    if (bP && !busyW && !pull && dirty && idle && !supplyLow) hwCnt <= DLY_CYC;
    if (!ceP && ceN && idle && busyW) begin
      if (!weP) begin
        if (!supplyLow && !wrBlk) begin
          mem[aP] = dP;
          dirty = 1'b1;
        end
        step <= 3'h0;
      end else if (step < 3'h5 && aP[15:0] == PRE[step]) begin
        step <= step + 3'h1;
      end else begin
        step <= {2'h0, aP[15:0] == SEQ_ADDR_0};
        if (step == 3'h5) begin
          case (aP[15:0])
            SEQ_ADDR_SAVE:    startSave();
            SEQ_ADDR_RESTORE: startRestore();
            SEQ_ADDR_PLS_DIS: plsEn <= 1'b0;
            SEQ_ADDR_PLS_EN:  plsEn <= 1'b1;
            default: ;
          endcase
        end
      end
    end
  end
endmodule

// ==== nsr_host_ctrl_test.sv ====
// self-checking bench for the host controller with a device model
`timescale 1ns/100ps
module nsr_host_ctrl_test;
  import nsr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmdValid = 1'b0;
  logic        supplyLow = 1'b0;
  nsr_op_e     cmdOp = NSR_OP_READ;
  nsr_op_e     op;
  nsr_op_e     plsOps [0:1] = '{NSR_OP_PLS_DISABLE, NSR_OP_PLS_ENABLE};
  logic [16:0] cmdAddr = 17'h00000;
  logic [16:0] sramAddr, a;
  logic [7:0]  cmdWrData = 8'h00;
  logic [7:0]  rspData, dqOut, devDq, got;
  logic        cmdReady, rspValid, sramCeN, sramWeN, sramOeN, dqOe, busyOut, busyOe, pull;
  logic [31:0] seed = 32'hB75C;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          saves;
  // open-drain busy line with pull-up, shared data pins
  wire         busyW = !((busyOe && !busyOut) || pull);
  wire [7:0]   dqIn = dqOe ? dqOut : devDq;
  always #2.5 clk = ~clk;
  nsr_host_ctrl #(.REQ_DELAY_CYC(20), .SAVE_CYC(50), .RESTORE_CYC(30), .PWRUP_CYC(10)) dut_u (.clk, .rst_n,
    .cmdValid, .cmdOp, .cmdAddr, .cmdWrData, .cmdReady, .rspValid, .rspData, .sramAddr, .sramCeN, .sramWeN,
    .sramOeN, .dqOut, .dqOe, .dqIn, .busyIn(busyW), .busyOut, .busyOe);
  nsr_dev_model dev_u (.clk, .addr(sramAddr), .ceN(sramCeN), .weN(sramWeN), .oeN(sramOeN), .dqIn, .busyW,
    .supplyLow, .dqOut(devDq), .pull);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic expPls(input nsr_op_e o);
    return o == NSR_OP_PLS_ENABLE;
  endfunction
  function automatic int expLoss(input int prev, input logic on, input logic wrote);
    return prev + ((on && wrote) ? 1 : 0);
  endfunction
  function automatic int expSaves(input int prev, input nsr_op_e o, input logic wrote);
    return prev + ((o != NSR_OP_HW_SAVE || wrote) ? 1 : 0);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask
  task automatic run(input nsr_op_e o, input logic [16:0] ad, input logic [7:0] d);
    @(posedge clk);
    cmdOp <= o;
    cmdAddr <= ad;
    cmdWrData <= d;
    cmdValid <= 1'b1;
    do @(negedge clk); while (cmdReady !== 1'b1);
    @(posedge clk);
    cmdValid <= 1'b0;
    do @(negedge clk); while (rspValid !== 1'b1);
    got = rspData;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // random writes read back, top address first
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 17'h1FFFF : seed[16:0];
      run(NSR_OP_WRITE, a, seed[24:17]);
      run(NSR_OP_READ, a, 8'h00);
      chk(got, seed[24:17]);
    end
    // both power-loss save settings
    foreach (plsOps[i]) begin
      run(plsOps[i], 17'h00000, 8'h00);
      chk(dev_u.plsEn, expPls(plsOps[i]));
    end
    // sequence save copies the array
    saves = dev_u.saveCnt;
    run(NSR_OP_SAVE, 17'h00000, 8'h00);
    chk(dev_u.saveCnt, expSaves(saves, NSR_OP_SAVE, 1'b1));
    chk(dev_u.nv[a], seed[24:17]);
    // overwrite, then restore brings the saved byte back
    run(NSR_OP_WRITE, a, ~seed[24:17]);
    run(NSR_OP_RESTORE, 17'h00000, 8'h00);
    run(NSR_OP_READ, a, 8'h00);
    chk(got, seed[24:17]);
    // hardware save without and with a write, then sequence save with none
    for (int k = 0; k < 3; k++) begin
      if (k == 1) run(NSR_OP_WRITE, a, 8'h5A);
      saves = dev_u.saveCnt;
      op = (k == 2) ? NSR_OP_SAVE : NSR_OP_HW_SAVE;
      run(op, 17'h00000, 8'h00);
      chk(dev_u.saveCnt, expSaves(saves, op, k == 1));
    end
    run(NSR_OP_READ, a, 8'h00);
    chk(got, 8'h5A);
    // supply loss with the loss save switched off, then on again after restore
    run(NSR_OP_PLS_DISABLE, 17'h00000, 8'h00);
    for (int p = 0; p < 2; p++) begin
      run(NSR_OP_WRITE, a, 8'hC3);
      saves = dev_u.saveCnt;
      @(posedge clk);
      supplyLow <= 1'b1;
      repeat (3) @(posedge clk);
      chk(dev_u.saveCnt, expLoss(saves, p == 1, 1'b1));
      chk(dev_u.nv[a], (p == 1) ? 8'hC3 : 8'h5A);
      run(NSR_OP_WRITE, a, 8'h3C);
      chk(dev_u.mem[a], 8'hC3);
      @(posedge clk);
      supplyLow <= 1'b0;
      repeat (20) @(posedge clk);
      run(NSR_OP_READ, a, 8'h00);
      chk(got, (p == 1) ? 8'hC3 : 8'h5A);
      chk(dev_u.plsEn, expPls(NSR_OP_PLS_ENABLE));
    end
    print_verdict();
  end
endmodule
